// [hw/burst_latency_cfg.sv]
// Burst address order generator and latency mode register with two set points
`timescale 1ns/1ps
`include "burst_latency_defs.svh"

module burst_latency_cfg (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          sys_rst_i,
    // Command bus, synchronous to clk_i
    input  wire burst_latency_pkg::cmd_t       cmd_i,
    output logic                               cmd_ready_o,
    output logic                               cmd_refused_o,
    // Configuration levels from neighbouring registers
    input  wire logic [1:0]                    burst_length_field_i,
    input  wire logic                          read_inversion_enable_i,
    input  wire logic                          setpoint_write_select_i,
    input  wire logic                          setpoint_operating_select_i,
    // Beat address stream
    output burst_latency_pkg::beat_t           beat_o,
    output logic                               beat_valid_o,
    input  wire logic                          beat_ready_i,
    // Active latency settings
    output burst_latency_pkg::latency_t        latency_o
);

    burst_latency_pkg::state_t s_reg;
    burst_latency_pkg::state_t s_next;
    burst_latency_pkg::beat_t  gen_beat;
    logic                      pop;
    logic                      push;
    logic                      is_long;
    logic [7:0]                act;
    logic [2:0]                rd_code;
    logic [2:0]                wr_code;

    //--------------------------------------------------------------------------
    // Lookup helper
    //--------------------------------------------------------------------------

    // Pick byte code out of an eight-entry table
    function automatic logic [7:0] pick(input logic [63:0] tbl, input logic [2:0] code);
        pick = tbl[{code, 3'h0} +: 8];
    endfunction : pick

    //--------------------------------------------------------------------------
    // Next state
    //--------------------------------------------------------------------------

    // Beat address for the current burst position
    always_comb begin
        gen_beat.is_write = s_reg.is_write;
        if (s_reg.is_write) begin
            // Linear order from block start; column bits 3..2 unused
            gen_beat.word = s_reg.long_burst ? s_reg.beat :
                            {s_reg.col[2], s_reg.beat[3:0]};
        end else begin
            // Wrap within the half, then the other half
            gen_beat.word = {s_reg.col[2] ^ s_reg.beat[4],
                             4'({s_reg.col[1:0], 2'h0} + s_reg.beat[3:0])};
        end
        gen_beat.last = (s_reg.beat == (s_reg.long_burst ? `BEAT_LAST_LONG :
                                                            `BEAT_LAST_SHORT));
    end

    // Burst length from mode, reserved codes fall back to 16
    always_comb begin
        case (burst_length_field_i)
            `BURST_FIXED_32: is_long = 1'b1;
            `BURST_PER_CMD:  is_long = cmd_i.long_burst;
            default:         is_long = 1'b0;
        endcase
    end

    assign pop  = s_reg.beat_valid && beat_ready_i;
    assign push = (s_reg.state == burst_latency_pkg::ST_BURST) &&
                  (s_reg.cnt != 2'h2 || pop);

    // Main state update
    always_comb begin
        s_next = s_reg;
        s_next.refused = 1'b0;
        // Two-entry buffer drain
        if (pop) begin
            s_next.ent0 = s_reg.ent1;
            s_next.cnt  = s_reg.cnt - 2'h1;
        end
        // Fill from the generator while there is room
        if (push) begin
            if (s_next.cnt == 2'h0) begin
                s_next.ent0 = gen_beat;
            end else begin
                s_next.ent1 = gen_beat;
            end
            s_next.cnt  = s_next.cnt + 2'h1;
            s_next.beat = s_reg.beat + 5'h1;
            if (gen_beat.last) begin
                s_next.state = burst_latency_pkg::ST_IDLE;
            end
        end
        // Command handling
        if (cmd_i.valid && s_reg.cmd_ready) begin
            case (s_reg.state)
                burst_latency_pkg::ST_IDLE: begin
                    if (cmd_i.kind == burst_latency_pkg::CMD_MODE_WRITE) begin
                        if (cmd_i.mr_addr == `LAT_REG_OFFSET) begin
                            s_next.copy[setpoint_write_select_i] = cmd_i.mr_data;
                            if (cmd_i.mr_data[`LAT_LEV_BIT] &&
                                setpoint_write_select_i == setpoint_operating_select_i) begin
                                s_next.state = burst_latency_pkg::ST_LEVEL;
                            end
                        end
                    end else if (cmd_i.kind == burst_latency_pkg::CMD_READ ||
                                 cmd_i.kind == burst_latency_pkg::CMD_WRITE) begin
                        s_next.state      = burst_latency_pkg::ST_BURST;
                        s_next.beat       = 5'h0;
                        s_next.col        = cmd_i.col;
                        s_next.long_burst = is_long;
                        s_next.is_write   = (cmd_i.kind == burst_latency_pkg::CMD_WRITE);
                    end
                end
                burst_latency_pkg::ST_LEVEL: begin
                    // Only the write that clears leveling is taken
                    if (cmd_i.kind == burst_latency_pkg::CMD_MODE_WRITE &&
                        cmd_i.mr_addr == `LAT_REG_OFFSET &&
                        !cmd_i.mr_data[`LAT_LEV_BIT]) begin
                        s_next.copy[setpoint_write_select_i] = cmd_i.mr_data;
                        if (setpoint_write_select_i == setpoint_operating_select_i) begin
                            s_next.state = burst_latency_pkg::ST_IDLE;
                        end
                    end else begin
                        s_next.refused = 1'b1;
                    end
                end
                default: s_next.state = s_reg.state;
            endcase
        end
        s_next.beat_valid = (s_next.cnt != 2'h0);
        s_next.cmd_ready  = (s_next.state != burst_latency_pkg::ST_BURST);
        // Settings from the operating copy only
        act     = s_next.copy[setpoint_operating_select_i];
        rd_code = act[`LAT_RDLAT_LSB +: 3];
        wr_code = act[`LAT_WRLAT_LSB +: 3];
        s_next.lat.read_latency = read_inversion_enable_i ?
                                  pick(`RDLAT_TABLE_INV, rd_code) :
                                  pick(`RDLAT_TABLE_PLAIN, rd_code);
        s_next.lat.read_to_precharge_cycles = pick(`RTP_TABLE, rd_code);
        s_next.lat.write_latency = act[`LAT_WRSET_BIT] ?
                                   pick(`WRLAT_TABLE_B, wr_code) :
                                   pick(`WRLAT_TABLE_A, wr_code);
        s_next.lat.leveling = act[`LAT_LEV_BIT];
    end

    //--------------------------------------------------------------------------
    // State register
    //--------------------------------------------------------------------------

    // Reset to default latencies, idle, empty buffer
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            s_reg                              <= '0;
            s_reg.copy                         <= {`LAT_REG_RESET, `LAT_REG_RESET};
            s_reg.cmd_ready                    <= 1'b1;
            s_reg.lat.read_latency             <= `LAT_RESET_READ;
            s_reg.lat.read_to_precharge_cycles <= `LAT_RESET_RTP;
            s_reg.lat.write_latency            <= `LAT_RESET_WRITE;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from state flops
    assign cmd_ready_o   = s_reg.cmd_ready;
    assign cmd_refused_o = s_reg.refused;
    assign beat_o        = s_reg.ent0;
    assign beat_valid_o  = s_reg.beat_valid;
    assign latency_o     = s_reg.lat;

    //--------------------------------------------------------------------------
    // Assertions
    //--------------------------------------------------------------------------

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    rd_wrap_order_a: assert property (
        push && !s_reg.is_write |->
        gen_beat.word[3:0] == 4'({s_reg.col[1:0], 2'h0} + s_reg.beat[3:0]))
        else $error("read beat out of wrap order");

    rd_half_swap_a: assert property (
        push && !s_reg.is_write && s_reg.beat[4] |-> gen_beat.word[4] != s_reg.col[2])
        else $error("long read second half wrong");

    wr_linear_a: assert property (
        push && s_reg.is_write |-> gen_beat.word[3:0] == s_reg.beat[3:0])
        else $error("write beat not linear");

    wr_upper_half_a: assert property (
        push && s_reg.is_write && !s_reg.long_burst |-> gen_beat.word[4] == s_reg.col[2])
        else $error("short write half select wrong");

    burst_length_a: assert property (
        cmd_i.valid && cmd_ready_o && cmd_i.kind == burst_latency_pkg::CMD_READ &&
        burst_length_field_i == `BURST_FIXED_16 && !latency_o.leveling
        |=> s_reg.state == burst_latency_pkg::ST_BURST ##0
            (s_reg.state == burst_latency_pkg::ST_BURST)[*1] ##0 !s_reg.long_burst)
        else $error("fixed 16 burst came out long");

    rd_first_beat_a: assert property (
        push && !s_reg.is_write && s_reg.beat == 5'h0 |-> gen_beat.word == {s_reg.col, 2'h0})
        else $error("read burst starts at wrong word");

    wr_first_beat_a: assert property (
        push && s_reg.is_write && s_reg.beat == 5'h0 |-> gen_beat.word[3:0] == 4'h0)
        else $error("write burst not at block start");

    level_hold_a: assert property (
        s_reg.state == burst_latency_pkg::ST_LEVEL && !(cmd_i.valid &&
        cmd_i.kind == burst_latency_pkg::CMD_MODE_WRITE && !cmd_i.mr_data[`LAT_LEV_BIT])
        |=> s_reg.state == burst_latency_pkg::ST_LEVEL)
        else $error("leveling left without clearing write");

    level_refuse_a: assert property (
        s_reg.state == burst_latency_pkg::ST_LEVEL && cmd_i.valid &&
        cmd_i.kind != burst_latency_pkg::CMD_MODE_WRITE |=> cmd_refused_o)
        else $error("command during leveling not refused");

    // The write taken at this edge goes to the copy that does not drive the outputs
    inactive_copy_a: assert property (
        setpoint_write_select_i != setpoint_operating_select_i &&
        $stable(setpoint_operating_select_i) && $stable(read_inversion_enable_i)
        |=> $stable(latency_o))
        else $error("inactive copy write changed operation");

    mrw_update_a: assert property (
        cmd_i.valid && cmd_ready_o && s_reg.state == burst_latency_pkg::ST_IDLE &&
        cmd_i.kind == burst_latency_pkg::CMD_MODE_WRITE && cmd_i.mr_addr == `LAT_REG_OFFSET
        |=> s_reg.copy[$past(setpoint_write_select_i)] == $past(cmd_i.mr_data) &&
            s_reg.copy[~$past(setpoint_write_select_i)] ==
            $past(s_reg.copy[~setpoint_write_select_i]))
        else $error("mode write landed in wrong copy");

    // Outputs this cycle were computed from this copy one edge earlier
    wl_set_b_a: assert property (
        s_reg.copy[setpoint_operating_select_i][`LAT_WRSET_BIT +: 2] == 2'h1 &&
        s_reg.copy[setpoint_operating_select_i][`LAT_WRLAT_LSB +: 3] == 3'h3 &&
        $stable(setpoint_operating_select_i) |-> latency_o.write_latency == 8'h12)
        else $error("write latency set B code 3 wrong");

    buf_no_loss_a: assert property (
        beat_valid_o && !beat_ready_i |=> beat_valid_o && $stable(beat_o))
        else $error("stalled beat lost");

    long_read_c:  cover property (
        push && !s_reg.is_write && s_reg.long_burst && gen_beat.last);
    long_write_c: cover property (
        push && s_reg.is_write && s_reg.long_burst && gen_beat.last);
    level_exit_c: cover property (
        s_reg.state == burst_latency_pkg::ST_LEVEL ##1
        s_reg.state == burst_latency_pkg::ST_IDLE);
    refuse_c:     cover property (cmd_refused_o);
    full_buf_c:   cover property (s_reg.cnt == 2'h2);

endmodule : burst_latency_cfg

// [hw/burst_latency_defs.svh]
// Constants for the burst order and latency configuration block
//--------------------------------------------------------------------------------
// Summary of operation
// - 16-beat read wraps within chosen half from C3:C2*4; 32-beat continues other half.
// - Read bursts start on four-word boundaries; column bits 2 and 3 are free.
// - Writes take data linearly from block start, words 0-15, 16-31 or 0-31.
// - Column bits 0 and 1 are never sent and count as zero.
// - Column bit four high on a 16-beat write stores into the upper half.
// - Inversion off: read latency codes give 6..40 with precharge spacing; default 000.
// - Inversion on: read latency codes give 6,12,18,24,30,36,40,44.
// - Write latency set A maps codes to 4..18 in steps of two.
// - Write latency set B maps codes to 4,8,12,18,22,26,30,34.
// - Latency register bit 6 selects write latency set; default set A.
// - Latency register bit 7 enables write leveling; default off.
// - After leveling is set, stay in that state until a write clears it.
// - Two register copies; a write updates only the write-selected set point.
// - Device runs only from the copy of the operating set point.
// - Writes to the inactive copy leave current operation unchanged.
// - Burst length field: 00 fixed 16, 01 fixed 32, 10 per command.
//--------------------------------------------------------------------------------
`ifndef BURST_LATENCY_DEFS_SVH
`define BURST_LATENCY_DEFS_SVH

// Register offset and field positions
`define LAT_REG_OFFSET   6'h02
`define LAT_REG_RESET    8'h00
`define LAT_RDLAT_LSB    0
`define LAT_WRLAT_LSB    3
`define LAT_WRSET_BIT    6
`define LAT_LEV_BIT      7

// Active latency values while in reset, code 000 of each table
`define LAT_RESET_READ   8'h06
`define LAT_RESET_RTP    8'h08
`define LAT_RESET_WRITE  8'h04

// Burst geometry
`define BEAT_LAST_SHORT  5'h0f
`define BEAT_LAST_LONG   5'h1f
`define BURST_FIXED_16   2'h0
`define BURST_FIXED_32   2'h1
`define BURST_PER_CMD    2'h2

// Latency tables, code 7 in the top byte, code 0 in the bottom byte
`define RDLAT_TABLE_PLAIN {8'h28, 8'h24, 8'h20, 8'h1a, 8'h16, 8'h10, 8'h0a, 8'h06}
`define RDLAT_TABLE_INV   {8'h2c, 8'h28, 8'h24, 8'h1e, 8'h18, 8'h12, 8'h0c, 8'h06}
`define RTP_TABLE         {8'h10, 8'h0e, 8'h0c, 8'h0a, 8'h08, 8'h08, 8'h08, 8'h08}
`define WRLAT_TABLE_A     {8'h12, 8'h10, 8'h0e, 8'h0c, 8'h0a, 8'h08, 8'h06, 8'h04}
`define WRLAT_TABLE_B     {8'h22, 8'h1e, 8'h1a, 8'h16, 8'h12, 8'h0c, 8'h08, 8'h04}

`endif

// [hw/burst_latency_pkg.sv]
// Types for the burst order and latency configuration block
package burst_latency_pkg;

    // Kinds of command on the command bus
    typedef enum logic [1:0] {
        CMD_READ  = 2'h0,
        CMD_WRITE = 2'h1,
        CMD_MODE_WRITE = 2'h2
    } cmd_kind_t;

    // Block state, one bit flips from idle to burst and from idle to leveling
    typedef enum logic [1:0] {
        ST_IDLE  = 2'h0,
        ST_BURST = 2'h1,
        ST_LEVEL = 2'h2
    } ctl_state_t;

    // One command from the controller
    typedef struct packed {
        logic      valid;
        cmd_kind_t kind;
        logic [2:0] col;       // Column bits 4..2
        logic      long_burst; // Per-command length, 1 = 32 beats
        logic [5:0] mr_addr;
        logic [7:0] mr_data;
    } cmd_t;

    // One beat of burst addressing
    typedef struct packed {
        logic [4:0] word;
        logic       is_write;
        logic       last;
    } beat_t;

    // Active latency settings
    typedef struct packed {
        logic [7:0] read_latency;
        logic [7:0] read_to_precharge_cycles;
        logic [7:0] write_latency;
        logic       leveling;
    } latency_t;

    // Whole state of the block
    typedef struct packed {
        ctl_state_t state;
        logic [1:0][7:0] copy;
        logic [4:0] beat;
        logic [2:0] col;
        logic       long_burst;
        logic       is_write;
        beat_t      ent0;
        beat_t      ent1;
        logic [1:0] cnt;
        logic       beat_valid;
        logic       cmd_ready;
        logic       refused;
        latency_t   lat;
    } state_t;

endpackage : burst_latency_pkg

// [verification/lpddr_ctl_model.sv]
// Memory controller model driving the command bus
`timescale 1ns/1ps
module lpddr_ctl_model (
    // Clock and set-point write select
    input  wire logic                    clk_i,
    input  wire logic                    setpoint_write_select_i,
    // Command bus
    output burst_latency_pkg::cmd_t      cmd_o,
    input  wire logic                    cmd_ready_i
);
    // Own copy of both set points, the register is write only
    logic [1:0][7:0] shadow_reg = '0;

    initial cmd_o = '0;

    // Send one command unless shadow leveling blocks it; hold it until taken, at most 200 edges
    task automatic issue(input logic [1:0] kind, input logic [2:0] col, input logic lng,
                         input logic [5:0] adr, input logic [7:0] dat, input logic bad);
        burst_latency_pkg::cmd_t c;
        int n;
        c.valid = 1'b1;
        c.kind = burst_latency_pkg::cmd_kind_t'(kind);
        c.col = col;
        c.long_burst = lng;
        c.mr_addr = adr;
        c.mr_data = dat;
        if (kind == 2'h1) c.col[1:0] = 2'h0;
        if (kind == 2'h1 && lng) c.col[2] = 1'b0;
        if (shadow_reg[setpoint_write_select_i][7] && !(kind == 2'h2 && !dat[7]) && !bad)
            return;
        if (kind == 2'h2 && adr == 6'h02) shadow_reg[setpoint_write_select_i] = dat;
        @(posedge clk_i);
        cmd_o <= c;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (!cmd_ready_i && n < 200);
        cmd_o.valid <= 1'b0;
    endtask : issue
endmodule : lpddr_ctl_model

// [verification/tb_burst_latency_cfg.sv]
// Self-checking bench for the burst order and latency block
`timescale 1ns/1ps
module tb_burst_latency_cfg;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [1:0] len_field = 2'h0;
    logic inv = 1'b0, wsel = 1'b0, osel = 1'b0, beat_ready_i = 1'b0;
    logic cmd_ready_o, cmd_refused_o, beat_valid_o;
    burst_latency_pkg::cmd_t cmd;
    burst_latency_pkg::beat_t beat_o;
    burst_latency_pkg::latency_t latency_o;
    burst_latency_pkg::beat_t got[$];
    int n_fail = 0, comparisons = 0, n_refused = 0, cycles = 0;
    logic [31:0] seed = 32'h786d, stall_seed = 32'h786d;

    always #25 clk_i = ~clk_i;

    lpddr_ctl_model ctl (.clk_i(clk_i), .setpoint_write_select_i(wsel), .cmd_o(cmd),
                         .cmd_ready_i(cmd_ready_o));

    burst_latency_cfg DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .cmd_i(cmd),
        .cmd_ready_o(cmd_ready_o), .cmd_refused_o(cmd_refused_o),
        .burst_length_field_i(len_field), .read_inversion_enable_i(inv),
        .setpoint_write_select_i(wsel), .setpoint_operating_select_i(osel),
        .beat_o(beat_o), .beat_valid_o(beat_valid_o), .beat_ready_i(beat_ready_i),
        .latency_o(latency_o));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h0);
    endfunction : lfsr

    // Sink with random stalls, collects beats, counts refusals, cuts hangs
    always @(posedge clk_i) begin
        stall_seed = lfsr(stall_seed);
        beat_ready_i <= stall_seed[1:0] != 2'h0;
        if (beat_valid_o && beat_ready_i) got.push_back(beat_o);
        if (cmd_refused_o) n_refused++;
        cycles++;
        if (cycles == 20000) begin
            n_fail++;
            report_and_stop();
        end
    end

    function automatic logic [4:0] exp_word(logic w, logic [2:0] col, logic l32, int i);
        logic [3:0] off;
        if (w) return l32 ? 5'(i) : {col[2], 4'(i)};
        off = 4'({col[1:0], 2'b00} + i);
        return {col[2] ^ (i > 15), off};
    endfunction : exp_word

    function automatic burst_latency_pkg::latency_t exp_lat(logic [2:0] c, logic i, logic s,
                                                            logic lev);
        int rp[8] = '{6, 10, 16, 22, 26, 32, 36, 40};
        int ri[8] = '{6, 12, 18, 24, 30, 36, 40, 44};
        int rt[8] = '{8, 8, 8, 8, 10, 12, 14, 16};
        int wa[8] = '{4, 6, 8, 10, 12, 14, 16, 18};
        int wb[8] = '{4, 8, 12, 18, 22, 26, 30, 34};
        burst_latency_pkg::latency_t e;
        e.read_latency = 8'(i ? ri[c] : rp[c]);
        e.read_to_precharge_cycles = 8'(rt[c]);
        e.write_latency = 8'(s ? wb[c] : wa[c]);
        e.leveling = lev;
        return e;
    endfunction : exp_lat

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    task automatic check_beat(input burst_latency_pkg::beat_t g, input burst_latency_pkg::beat_t e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: beat %h want %h", $time, g, e);
        end
    endtask : check_beat

    task automatic check_lat(input burst_latency_pkg::latency_t e);
        comparisons++;
        if (latency_o !== e) begin
            n_fail++;
            $display("unexpected at %0t: latency %h want %h", $time, latency_o, e);
        end
    endtask : check_lat

    task automatic check_cnt(input int g, input int e);
        comparisons++;
        if (g != e) begin
            n_fail++;
            $display("unexpected at %0t: count %0d want %0d", $time, g, e);
        end
    endtask : check_cnt

    task automatic check_flag(input logic g, input logic e);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("unexpected at %0t: flag %b want %b", $time, g, e);
        end
    endtask : check_flag

    // Mode register write, then let the settings land
    task automatic mode_register_write_cmd(input logic [7:0] d, input logic bad);
        ctl.issue(2'h2, 3'h0, 1'b0, 6'h02, d, bad);
        repeat (3) @(posedge clk_i);
    endtask : mode_register_write_cmd

    // One burst, collected and compared beat by beat
    task automatic run_burst(input logic w, input logic [2:0] col, input logic l32,
                             input logic [1:0] fld);
        burst_latency_pkg::beat_t e;
        int len, k;
        len_field <= fld;
        @(posedge clk_i);
        len = l32 ? 32 : 16;
        got.delete();
        ctl.issue({1'b0, w}, col, l32, 6'h00, 8'h00, 1'b0);
        @(posedge clk_i);
        check_flag(cmd_ready_o, 1'b0);
        k = 0;
        while (got.size() < len && k < 400) begin
            @(posedge clk_i);
            k++;
        end
        repeat (4) @(posedge clk_i);
        check_flag(cmd_ready_o, 1'b1);
        check_cnt(got.size(), len);
        for (int i = 0; i < len && i < got.size(); i++) begin
            e.word = exp_word(w, col, l32, i);
            e.is_write = w;
            e.last = (i == len - 1);
            check_beat(got[i], e);
        end
    endtask : run_burst

    initial begin
        logic w, l32;
        logic [1:0] f;
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check_lat(exp_lat(3'h0, 1'b0, 1'b0, 1'b0));
        $display("test reset done");
        for (int m = 0; m < 32; m++) begin
            inv <= m[4];
            mode_register_write_cmd({1'b0, m[3], m[2:0], m[2:0]}, 1'b0);
            check_lat(exp_lat(m[2:0], m[4], m[3], 1'b0));
        end
        $display("test latency tables done");
        wsel <= 1'b1;
        mode_register_write_cmd(8'h00, 1'b0);
        check_lat(exp_lat(3'h7, 1'b1, 1'b1, 1'b0));
        osel <= 1'b1;
        repeat (3) @(posedge clk_i);
        check_lat(exp_lat(3'h0, 1'b1, 1'b0, 1'b0));
        osel <= 1'b0;
        wsel <= 1'b0;
        repeat (3) @(posedge clk_i);
        check_lat(exp_lat(3'h7, 1'b1, 1'b1, 1'b0));
        $display("test set points done");
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check_lat(exp_lat(3'h0, 1'b1, 1'b0, 1'b0));
        check_flag(cmd_ready_o, 1'b1);
        check_flag(beat_valid_o, 1'b0);
        $display("test mid-run reset done");
        mode_register_write_cmd(8'h80, 1'b0);
        check_lat(exp_lat(3'h0, 1'b1, 1'b0, 1'b1));
        got.delete();
        ctl.issue(2'h0, 3'h1, 1'b0, 6'h00, 8'h00, 1'b1);
        repeat (6) @(posedge clk_i);
        check_cnt(n_refused, 1);
        check_cnt(got.size(), 0);
        mode_register_write_cmd(8'h00, 1'b0);
        check_lat(exp_lat(3'h0, 1'b1, 1'b0, 1'b0));
        $display("test leveling done");
        for (int j = 0; j < 40; j++) begin
            seed = lfsr(seed);
            w = (j < 16) ? 1'b0 : (j < 18) ? 1'b1 : seed[0];
            f = (j < 16) ? 2'h2 : (j == 16) ? 2'h0 : (j == 17) ? 2'h1 : seed[2:1];
            l32 = (f == 2'h1) || (f == 2'h2 && ((j < 16) ? j[3] : seed[3]));
            if (j < 16) run_burst(1'b0, j[2:0], l32, f);
            else if (j == 16) run_burst(1'b1, 3'h4, 1'b0, f);
            else run_burst(w, w ? {seed[4] & !l32, 2'h0} : seed[6:4], l32, f);
        end
        $display("test bursts done");
        report_and_stop();
    end
endmodule : tb_burst_latency_cfg
